// *** logic/pmtr_pkg.sv ***
package pmtr_pkg;
    localparam int unsigned PMTR_CLK_PERIOD_PS = 8000;
    // Chip select high longer than this counts as a refresh opportunity
    localparam int unsigned PMTR_OPP_HIGH_PS = 15000;
    localparam int unsigned PMTR_OPP_HIGH_CYC_RAW =
        (PMTR_OPP_HIGH_PS + PMTR_CLK_PERIOD_PS - 1) / PMTR_CLK_PERIOD_PS;
    localparam logic [3:0] PMTR_OPP_HIGH_CYC = PMTR_OPP_HIGH_CYC_RAW[3:0];
    // Least chip-select-high time after a write in synchronous mode, or after an async write ended by chip select
    localparam int unsigned PMTR_MIN_HIGH_PS = 5000;
    localparam int unsigned PMTR_MIN_HIGH_CYC_RAW =
        (PMTR_MIN_HIGH_PS + PMTR_CLK_PERIOD_PS - 1) / PMTR_CLK_PERIOD_PS;
    localparam logic [3:0] PMTR_MIN_HIGH_CYC = PMTR_MIN_HIGH_CYC_RAW[3:0];
    // Configuration register fields
    localparam int unsigned PMTR_CFG_SYNC_N_BIT = 15;
    localparam int unsigned PMTR_CFG_LC_MSB = 13;
    localparam int unsigned PMTR_CFG_LC_LSB = 11;
    localparam int unsigned PMTR_CFG_FIXED_BIT = 14;
    localparam logic [2:0] PMTR_LC_OFFSET = 3'h1;
    localparam logic [15:0] PMTR_CFG_RESET = 16'h9D1F;

    typedef enum logic [2:0] {
        PMTR_IDLE,
        PMTR_ASYNC_WR,
        PMTR_ASYNC_RD,
        PMTR_BURST_WAIT,
        PMTR_BURST_DATA
    } pmtr_state_t;
endpackage : pmtr_pkg

// *** logic/pmtr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pmtr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1 <= '1;
            sync_out <= '1;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : pmtr_sync
`default_nettype wire

// *** logic/pmtr_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module pmtr_core
    import pmtr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic link_clk,
    input wire logic select_n,
    input wire logic address_valid_n,
    input wire logic write_n,
    input wire logic [15:0] bus_config_reg,
    output logic wait_active,
    output logic refresh_opportunity,
    output logic async_start,
    output logic burst_start,
    output logic transition_error,
    output logic [2:0] op_state
);
    logic [3:0] pins_s;
    logic link_clk_q, sel_n_q, adv_n_q;
    logic [3:0] high_cnt;
    logic [2:0] wait_cnt;
    logic last_was_write, last_sync_var, wrote_by_select;
    // Set once an async access has run to its end under the current select
    logic async_done;
    logic next_async_done;
    pmtr_state_t state, next_state;

    // True for either kind of asynchronous access state
    function automatic logic is_async(input pmtr_state_t s);
        return s == PMTR_ASYNC_WR || s == PMTR_ASYNC_RD;
    endfunction : is_async

    pmtr_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in({link_clk, select_n, address_valid_n, write_n}),
        .sync_out(pins_s)
    );

    wire lclk = pins_s[3];
    wire sel_n = pins_s[2];
    wire adv_n = pins_s[1];
    wire wr_n = pins_s[0];
    wire lclk_rise = lclk && !link_clk_q;
    wire adv_fall = !adv_n && adv_n_q && !sel_n;
    wire sel_rise = sel_n && !sel_n_q;
    wire sync_mode = !bus_config_reg[PMTR_CFG_SYNC_N_BIT];
    wire fixed_lat = bus_config_reg[PMTR_CFG_FIXED_BIT];
    wire [2:0] lat_code = bus_config_reg[PMTR_CFG_LC_MSB:PMTR_CFG_LC_LSB];
    // Code 2 gives 3 clocks in either latency mode
    wire [2:0] lat_clocks = lat_code + PMTR_LC_OFFSET;
    wire clocked_high = sel_n && lclk_rise;
    wire long_high = sel_n && (high_cnt >= PMTR_OPP_HIGH_CYC);
    wire opp = clocked_high || long_high;
    // Burst when link clock ticks at address-valid low in sync mode
    // The burst's own address-valid fall reaches the state machine before the
    // first link clock edge, so the async states must stay open to a burst.
    wire burst_req = sync_mode && !adv_n && !sel_n && lclk_rise &&
        (state == PMTR_IDLE || is_async(state));
    // Variable-latency burst after a finished async access needs a deselect
    wire need_desel = burst_req && !fixed_lat && async_done;
    wire adv_rise = adv_n && !adv_n_q;
    wire async_end = is_async(state) && adv_rise && !sel_n;
    // Deselect or an accepted burst forgets the finished access
    assign next_async_done = (sel_n || next_state == PMTR_BURST_WAIT) ? 1'b0 :
        (async_done || async_end);
    wire need_min = (sync_mode || wrote_by_select) && last_was_write;
    wire short_high = sel_rise ? 1'b0 : (!sel_n && sel_n_q && need_min &&
        high_cnt < PMTR_MIN_HIGH_CYC);

    always_comb begin
        next_state = state;
        case (state)
            PMTR_IDLE, PMTR_ASYNC_WR, PMTR_ASYNC_RD: begin
                if (burst_req && !need_desel) begin
                    next_state = PMTR_BURST_WAIT;
                end else if (adv_fall) begin
                    next_state = wr_n ? PMTR_ASYNC_RD : PMTR_ASYNC_WR;
                end
            end
            PMTR_BURST_WAIT: begin
                if (lclk_rise && wait_cnt <= 3'h1) begin
                    next_state = PMTR_BURST_DATA;
                end
            end
            PMTR_BURST_DATA: begin
                // Fixed-latency bursts may drop straight into async read or write
                if (adv_fall && fixed_lat) begin
                    next_state = wr_n ? PMTR_ASYNC_RD : PMTR_ASYNC_WR;
                end
            end
            default: next_state = PMTR_IDLE;
        endcase
        if (sel_n) begin
            next_state = PMTR_IDLE;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            // The synchroniser leaves reset high; matching it avoids a false
            // link clock rise on the first edge after reset.
            link_clk_q <= 1'b1;
            sel_n_q <= 1'b1;
            adv_n_q <= 1'b1;
        end else begin
            link_clk_q <= lclk;
            sel_n_q <= sel_n;
            adv_n_q <= adv_n;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            high_cnt <= 4'h0;
        end else if (!sel_n_q || !sel_n) begin
            high_cnt <= sel_n ? 4'h1 : high_cnt;
        end else if (high_cnt != 4'hF) begin
            high_cnt <= high_cnt + 4'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= PMTR_IDLE;
            wait_cnt <= 3'h0;
        end else begin
            state <= next_state;
            if (next_state == PMTR_BURST_WAIT && state != PMTR_BURST_WAIT) begin
                wait_cnt <= lat_clocks;
            end else if (state == PMTR_BURST_WAIT && lclk_rise && wait_cnt != 3'h0) begin
                wait_cnt <= wait_cnt - 3'h1;
            end
        end
    end

    // Tracks how the last write ended, for the minimum-high check
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            last_was_write <= 1'b0;
            wrote_by_select <= 1'b0;
            last_sync_var <= 1'b0;
        end else begin
            last_sync_var <= sync_mode && !fixed_lat;
            if (state == PMTR_ASYNC_WR && sel_rise) begin
                last_was_write <= 1'b1;
                wrote_by_select <= !wr_n;
            end else if (state == PMTR_ASYNC_RD || state == PMTR_BURST_WAIT) begin
                last_was_write <= 1'b0;
                wrote_by_select <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            async_done <= 1'b0;
        end else begin
            async_done <= next_async_done;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wait_active <= 1'b0;
        end else begin
            wait_active <= (next_state == PMTR_BURST_WAIT);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            refresh_opportunity <= 1'b0;
        end else begin
            refresh_opportunity <= opp;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            async_start <= 1'b0;
        end else begin
            async_start <= is_async(next_state) && adv_fall;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            burst_start <= 1'b0;
        end else begin
            burst_start <= (next_state == PMTR_BURST_WAIT && state != PMTR_BURST_WAIT);
        end
    end

    // A refused burst leaves the state alone; only this pulse reports it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            transition_error <= 1'b0;
        end else begin
            transition_error <= need_desel || short_high;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            op_state <= 3'h0;
        end else begin
            op_state <= 3'(state);
        end
    end
endmodule : pmtr_core
`default_nettype wire

// *** test/pmtr_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module pmtr_sva
    import pmtr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic select_n,
    input wire logic address_valid_n,
    input wire logic [15:0] bus_config_reg,
    input wire logic wait_active,
    input wire logic refresh_opportunity,
    input wire logic async_start,
    input wire logic burst_start,
    input wire logic [2:0] op_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_wait_lc2;
        $rose(wait_active) && bus_config_reg[13:11] == 3'h2;
    endsequence
    a_opp_on_high: assert property (select_n [*8] |-> refresh_opportunity)
        else $error("no refresh opportunity while deselected");
    a_no_opp_low: assert property (!select_n [*8] |-> !refresh_opportunity)
        else $error("refresh opportunity while selected");
    a_async_needs_adv: assert property (address_valid_n [*8] |-> !async_start)
        else $error("async start without address valid fall");
    a_async_state: assert property (async_start |->
        ##[0:2] op_state inside {PMTR_ASYNC_WR, PMTR_ASYNC_RD})
        else $error("async start without async state");
    a_burst_waits: assert property (burst_start |-> ##[0:3] wait_active)
        else $error("burst start without wait");
    a_wait_ends: assert property (s_wait_lc2 |-> ##[36:56] !wait_active)
        else $error("wait too long for code two");
    a_wait_holds: assert property ($fell(wait_active) && bus_config_reg[13:11] == 3'h2
        |-> $past(wait_active, 36))
        else $error("wait too short for code two");
endmodule : pmtr_sva
bind pmtr_core pmtr_sva pmtr_sva_inst (.clk, .reset, .select_n, .address_valid_n,
    .bus_config_reg, .wait_active, .refresh_opportunity, .async_start, .burst_start,
    .op_state);
`default_nettype wire

// *** test/pmtr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module pmtr_host (
    input wire logic clk,
    output logic select_n,
    output logic address_valid_n,
    output logic write_n,
    output logic link_clk
);
    initial begin
        select_n = 1'b1;
        address_valid_n = 1'b1;
        write_n = 1'b1;
        link_clk = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Select held high for n cycles, so refresh can be scheduled
    task automatic deselect(input int n);
        tick(1);
        select_n = 1'b1;
        tick(n);
        select_n = 1'b0;
    endtask : deselect
    task automatic async_op(input logic wr);
        tick(1);
        select_n = 1'b0;
        address_valid_n = 1'b0;
        write_n = !wr;
        tick(8);
        address_valid_n = 1'b1;
        write_n = 1'b1;
        tick(8);
    endtask : async_op
    // Link clock runs only within a burst; the core must not see stray edges
    task automatic burst(input int rises);
        tick(1);
        select_n = 1'b0;
        address_valid_n = 1'b0;
        repeat (rises) begin
            #62.5 link_clk = 1'b1;
            #62.5 link_clk = 1'b0;
            address_valid_n = 1'b1;
        end
        tick(8);
    endtask : burst
endmodule : pmtr_host
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pmtr_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] cfg = 16'h0000;
    logic select_n, address_valid_n, write_n, link_clk, wait_active;
    logic refresh_opportunity, async_start, burst_start, transition_error;
    logic [2:0] op_state;
    int error_cnt = 0;
    int checks_done = 0;
    int n_async, n_burst, n_err, n_opp, n_wait, lc;
    logic fx;
    always #4 clk = ~clk;
    pmtr_host pmtr_host_inst (.clk, .select_n, .address_valid_n, .write_n, .link_clk);
    pmtr_core pmtr_core_inst (.clk, .reset, .link_clk, .select_n, .address_valid_n,
        .write_n, .bus_config_reg(cfg), .wait_active, .refresh_opportunity, .async_start,
        .burst_start, .transition_error, .op_state);
    always @(posedge clk) begin
        n_async += (async_start === 1'b1);
        n_burst += (burst_start === 1'b1);
        n_err += (transition_error === 1'b1);
        n_opp += (refresh_opportunity === 1'b1);
        n_wait += (wait_active === 1'b1);
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    // Sampling jitter of the link clock allows a few cycles either way
    function automatic logic wait_ok(input int w, input int code);
        int e;
        e = (code + 1) * 125 / 8;
        return w >= e - 3 && w <= e + 3;
    endfunction : wait_ok
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        #200000;
        error_cnt++;
        report_and_stop;
    end
    initial begin
        void'($urandom(18347));
        repeat (3) @(posedge clk);
        #1;
        check("reset outputs", {wait_active, refresh_opportunity, async_start,
            burst_start, transition_error, op_state}, 16'h0000);
        reset = 1'b0;
        for (int n = 1; n < 8; n += 5) begin
            {n_async, n_burst, n_err, n_opp, n_wait} = '0;
            pmtr_host_inst.deselect(n);
            pmtr_host_inst.tick(6);
            check("opportunity", n_opp != 0, 1'b1);
        end
        $display("test opportunity done");
        cfg = 16'h5000;
        {n_async, n_burst, n_err, n_opp, n_wait} = '0;
        pmtr_host_inst.async_op(1'b1);
        pmtr_host_inst.burst(6);
        check("fixed burst_start", n_burst, 16'h0001);
        check("fixed transition_error", n_err, 16'h0000);
        check("wait length", wait_ok(n_wait, 2), 1'b1);
        {n_async, n_burst, n_err, n_opp, n_wait} = '0;
        pmtr_host_inst.async_op(1'b1);
        check("async_start", n_async, 16'h0001);
        $display("test fixed done");
        cfg = 16'h1000;
        pmtr_host_inst.deselect(4);
        {n_async, n_burst, n_err, n_opp, n_wait} = '0;
        pmtr_host_inst.async_op(1'b1);
        pmtr_host_inst.burst(6);
        check("refused burst_start", n_burst, 16'h0000);
        check("refused transition_error", n_err, 16'h0001);
        $display("test refused done");
        repeat (20) begin
            lc = $urandom_range(1, 6);
            fx = 1'($urandom_range(0, 1));
            cfg = {1'b0, fx, lc[2:0], 11'($urandom)};
            pmtr_host_inst.deselect($urandom_range(2, 6));
            {n_async, n_burst, n_err, n_opp, n_wait} = '0;
            pmtr_host_inst.burst(lc + 4);
            check("burst_start", n_burst, 16'h0001);
            check("wait length", wait_ok(n_wait, lc), 1'b1);
            if (!fx)
                pmtr_host_inst.deselect(2);
            {n_async, n_burst, n_err, n_opp, n_wait} = '0;
            pmtr_host_inst.async_op(1'($urandom_range(0, 1)));
            check("async_start", n_async, 16'h0001);
        end
        $display("test random done");
        report_and_stop;
    end
endmodule : tb_top
`default_nettype wire
